// >>> hdl/ref_cond_map.svh
// offsets, field positions, reset values and scale constants of the speed reference conditioner
// assumes 10-bit converter codes and frequencies in 0.1 Hz units
`ifndef REF_COND_MAP_SVH
`define REF_COND_MAP_SVH
`define ADC_W 10
`define ADC_FS 17'h003ff
`define PCT_SCALE 17'h00064
`define FREQ_W 12
`define FREQ_MAX 12'hfa0
`define PCT_MAX 7'h64
`define FIFO_DEPTH 16
`define HIST_DEPTH 16
`define FILT_DB 5'h11
`define FILT_AVG_MAX 5'h10
`define FILT_DEF_EU 5'h02
`define FILT_DEF_US 5'h08
`define DB_RISE 12'h001
`define DB_FALL 12'h002
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_VOLT_FREQ 8'h04
`define OFS_VOLT_WIN 8'h08
`define OFS_CURR_FREQ 8'h0c
`define OFS_CURR_WIN 8'h10
`define OFS_STATUS 8'h14
`define CTRL_SEL_LSB 0
`define CTRL_VMODE_BIT 2
`define CTRL_CMODE_BIT 3
`define CTRL_FILT_LSB 4
`define STAT_HELD_BIT 24
`define HI_LSB 16
`define SEL_RST 2'h0
`define BELOW_RST 1'b1
`define FREQ_RST 12'h000
`define WIN_START_RST 7'h00
`define WIN_END_RST 7'h64
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hdl/ref_cond_pkg.sv
// types shared by the speed reference conditioner and its sample buffer
// assumes ref_cond_map.svh sits beside it
package ref_cond_pkg;
`include "ref_cond_map.svh"

  typedef struct packed {
    logic [`ADC_W-1:0] pot;
    logic [`ADC_W-1:0] curr;
    logic [`ADC_W-1:0] volt;
  } sample_set_type;

  typedef struct packed {
    logic [`FREQ_W-1:0] start_freq;
    logic [`FREQ_W-1:0] end_freq;
    logic [6:0] win_start;
    logic [6:0] win_end;
    logic below_zero;
  } chan_cfg_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_AVG = 2'b01,
    ST_OUT = 2'b10
  } proc_state_type;
endpackage : ref_cond_pkg

// >>> hdl/analog_speed_reference_conditioner.sv
// analog speed reference conditioner: sample buffer, channel mapping, averaging, deadband
// assumes samples and channel select synchronous to clk; registers over AXI4-Lite
`timescale 1ns/1ps
`include "ref_cond_map.svh"

module sample_fifo
  import ref_cond_pkg::*;
#(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic in_ready_r;
  logic push;
  logic pop;

  assign in_ready = in_ready_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready_r;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (!push && pop)
      count_nxt = count_r - 1'b1;
  end

  // ready is registered so the source sees a flop, depth must be a power of two
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end
endmodule : sample_fifo

module analog_speed_reference_conditioner
  import ref_cond_pkg::*;
#(
  parameter bit US_VARIANT = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`ADC_W-1:0] volt_ref_channel,
  input wire logic [`ADC_W-1:0] current_ref_channel,
  input wire logic [`ADC_W-1:0] pot_ref_channel,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic channel_select_input,
  output logic [`FREQ_W-1:0] freq_ref,
  output logic freq_ref_valid,
  input wire logic freq_ref_ready,
  output logic [4:0] filter_sample_display
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_hold_r, w_hold_r;
  logic [`ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic do_write;
  logic [1:0] input_select_code_r;
  logic [4:0] ref_filter_setting_r;
  chan_cfg_type volt_cfg_r, curr_cfg_r;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  proc_state_type state_r;
  sample_set_type head;
  logic head_valid, pop;
  logic [`FREQ_W-1:0] hist_r [`HIST_DEPTH];
  logic [3:0] wr_idx_r;
  logic [`FREQ_W-1:0] raw_ref, avg, held_r, freq_ref_r;
  logic held_valid_r, freq_ref_valid_r;
  logic [4:0] navg;
  logic [15:0] sum;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        m[b*8 +: 8] = d[b*8 +: 8];
    return m;
  endfunction : merge

  function automatic logic reg_hit(input logic [`ADDR_W-1:0] a);
    return a == `OFS_CTRL || a == `OFS_VOLT_FREQ || a == `OFS_VOLT_WIN ||
           a == `OFS_CURR_FREQ || a == `OFS_CURR_WIN || a == `OFS_STATUS;
  endfunction : reg_hit

  function automatic logic [`FREQ_W-1:0] clamp_freq(input logic [15:0] v);
    return (v > 16'(`FREQ_MAX)) ? `FREQ_MAX : v[`FREQ_W-1:0];
  endfunction : clamp_freq

  function automatic logic [6:0] clamp_pct(input logic [15:0] v);
    return (v > 16'(`PCT_MAX)) ? `PCT_MAX : v[6:0];
  endfunction : clamp_pct

  function automatic logic [4:0] clamp_filt(input logic [7:0] v);
    if (v == 8'h00)
      return 5'h01;
    return (v > 8'(`FILT_DB)) ? `FILT_DB : v[4:0];
  endfunction : clamp_filt

  function automatic logic [`FREQ_W-1:0] sat_add(input logic [`FREQ_W-1:0] a,
                                                 input logic [`FREQ_W-1:0] b);
    logic [`FREQ_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, `FREQ_MAX}) ? `FREQ_MAX : s[`FREQ_W-1:0];
  endfunction : sat_add

  // window compare is done on code*100 against percent*full-scale, so no division there
  function automatic logic [`FREQ_W-1:0] map_chan(input logic [`ADC_W-1:0] x,
                                                  input chan_cfg_type c);
    logic [16:0] pos, ws, we;
    logic [`FREQ_W-1:0] df;
    logic [28:0] prod;
    logic [28:0] quo;
    pos = 17'(x) * `PCT_SCALE;
    ws = 17'(c.win_start) * `ADC_FS;
    we = 17'(c.win_end) * `ADC_FS;
    if (pos < ws)
      return c.below_zero ? `FREQ_RST : c.start_freq;
    if (pos >= we)
      return c.end_freq;
    df = (c.end_freq >= c.start_freq) ? c.end_freq - c.start_freq
                                      : c.start_freq - c.end_freq;
    prod = 29'(df) * 29'(pos - ws);
    quo = prod / 29'(we - ws);
    if (c.end_freq >= c.start_freq)
      return c.start_freq + quo[`FREQ_W-1:0];
    return c.start_freq - quo[`FREQ_W-1:0];
  endfunction : map_chan

  // the pot has no programmable window: its full travel spans 0 to the frequency limit
  function automatic logic [`FREQ_W-1:0] pot_map(input logic [`ADC_W-1:0] x);
    logic [28:0] q;
    q = (29'(x) * 29'(`FREQ_MAX)) / 29'(`ADC_FS);
    return q[`FREQ_W-1:0];
  endfunction : pot_map

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign freq_ref = freq_ref_r;
  assign freq_ref_valid = freq_ref_valid_r;
  assign filter_sample_display = ref_filter_setting_r;
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_r)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (do_write)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= reg_hit(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rd_word = '0;
    case (s_axi_araddr)
      `OFS_CTRL:
      begin
        rd_word[`CTRL_SEL_LSB +: 2] = input_select_code_r;
        rd_word[`CTRL_VMODE_BIT] = volt_cfg_r.below_zero;
        rd_word[`CTRL_CMODE_BIT] = curr_cfg_r.below_zero;
        rd_word[`CTRL_FILT_LSB +: 5] = ref_filter_setting_r;
      end
      `OFS_VOLT_FREQ: rd_word = {4'h0, volt_cfg_r.end_freq, 4'h0, volt_cfg_r.start_freq};
      `OFS_VOLT_WIN: rd_word = {9'h000, volt_cfg_r.win_end, 9'h000, volt_cfg_r.win_start};
      `OFS_CURR_FREQ: rd_word = {4'h0, curr_cfg_r.end_freq, 4'h0, curr_cfg_r.start_freq};
      `OFS_CURR_WIN: rd_word = {9'h000, curr_cfg_r.win_end, 9'h000, curr_cfg_r.win_start};
      `OFS_STATUS:
      begin
        rd_word[`FREQ_W-1:0] = freq_ref_r;
        rd_word[`HI_LSB +: 5] = ref_filter_setting_r;
        rd_word[`STAT_HELD_BIT] = held_valid_r;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= reg_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  always_comb
  begin
    wr_word = '0;
    case (aw_addr_r)
      `OFS_CTRL: wr_word = {23'h000000, ref_filter_setting_r, curr_cfg_r.below_zero,
                            volt_cfg_r.below_zero, input_select_code_r};
      `OFS_VOLT_FREQ: wr_word = {4'h0, volt_cfg_r.end_freq, 4'h0, volt_cfg_r.start_freq};
      `OFS_VOLT_WIN: wr_word = {9'h000, volt_cfg_r.win_end, 9'h000, volt_cfg_r.win_start};
      `OFS_CURR_FREQ: wr_word = {4'h0, curr_cfg_r.end_freq, 4'h0, curr_cfg_r.start_freq};
      `OFS_CURR_WIN: wr_word = {9'h000, curr_cfg_r.win_end, 9'h000, curr_cfg_r.win_start};
      default: wr_word = '0;
    endcase
    wr_word = merge(wr_word, w_data_r, w_strb_r);
  end

  // written values are clamped to their legal ranges rather than refused
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_select_code_r <= `SEL_RST;
      ref_filter_setting_r <= US_VARIANT ? `FILT_DEF_US : `FILT_DEF_EU;
      volt_cfg_r <= '{`FREQ_RST, `FREQ_RST, `WIN_START_RST, `WIN_END_RST, `BELOW_RST};
      curr_cfg_r <= '{`FREQ_RST, `FREQ_RST, `WIN_START_RST, `WIN_END_RST, `BELOW_RST};
    end
    else if (do_write)
    begin
      case (aw_addr_r)
        `OFS_CTRL:
        begin
          input_select_code_r <= wr_word[`CTRL_SEL_LSB +: 2];
          volt_cfg_r.below_zero <= wr_word[`CTRL_VMODE_BIT];
          curr_cfg_r.below_zero <= wr_word[`CTRL_CMODE_BIT];
          ref_filter_setting_r <= clamp_filt(wr_word[`CTRL_FILT_LSB +: 8]);
        end
        `OFS_VOLT_FREQ:
        begin
          volt_cfg_r.start_freq <= clamp_freq(wr_word[15:0]);
          volt_cfg_r.end_freq <= clamp_freq(wr_word[31:16]);
        end
        `OFS_VOLT_WIN:
        begin
          volt_cfg_r.win_start <= clamp_pct(wr_word[15:0]);
          volt_cfg_r.win_end <= clamp_pct(wr_word[31:16]);
        end
        `OFS_CURR_FREQ:
        begin
          curr_cfg_r.start_freq <= clamp_freq(wr_word[15:0]);
          curr_cfg_r.end_freq <= clamp_freq(wr_word[31:16]);
        end
        `OFS_CURR_WIN:
        begin
          curr_cfg_r.win_start <= clamp_pct(wr_word[15:0]);
          curr_cfg_r.win_end <= clamp_pct(wr_word[31:16]);
        end
        default: ;
      endcase
    end
  end

  sample_fifo #(
    .WIDTH($bits(sample_set_type)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data({pot_ref_channel, current_ref_channel, volt_ref_channel}),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(pop)
  );

  // a sample is only drawn while the previous result is fully delivered
  assign pop = head_valid && (state_r == ST_IDLE);

  always_comb
  begin
    case (input_select_code_r)
      2'h0: raw_ref = channel_select_input ? map_chan(head.curr, curr_cfg_r)
                                           : map_chan(head.volt, volt_cfg_r);
      2'h1: raw_ref = sat_add(map_chan(head.volt, volt_cfg_r),
                              map_chan(head.curr, curr_cfg_r));
      2'h2: raw_ref = channel_select_input ? pot_map(head.pot)
                                           : map_chan(head.volt, volt_cfg_r);
      default: raw_ref = channel_select_input ? pot_map(head.pot)
                                              : map_chan(head.curr, curr_cfg_r);
    endcase
  end

  always_comb
  begin
    navg = (ref_filter_setting_r == `FILT_DB) ? `FILT_AVG_MAX : ref_filter_setting_r;
    sum = '0;
    for (int k = 0; k < `HIST_DEPTH; k++)
      if (5'(k) < navg)
        sum = sum + 16'(hist_r[4'(wr_idx_r - 4'(k) - 4'h1)]);
    avg = (`FREQ_W)'(sum / 16'(navg));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `HIST_DEPTH; i++)
        hist_r[i] <= `FREQ_RST;
      wr_idx_r <= '0;
    end
    else if (pop)
    begin
      hist_r[wr_idx_r] <= raw_ref;
      wr_idx_r <= wr_idx_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      freq_ref_r <= `FREQ_RST;
      freq_ref_valid_r <= 1'b0;
      held_r <= `FREQ_RST;
      held_valid_r <= 1'b0;
    end
    else
    begin
      if (ref_filter_setting_r != `FILT_DB)
        held_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (pop)
            state_r <= ST_AVG;
        ST_AVG:
        begin
          state_r <= ST_OUT;
          freq_ref_valid_r <= 1'b1;
          if (ref_filter_setting_r != `FILT_DB)
            freq_ref_r <= avg;
          else if (!held_valid_r || (avg >= held_r + `DB_RISE && avg > held_r) ||
                   (held_r >= avg + `DB_FALL))
          begin
            held_r <= avg;
            held_valid_r <= 1'b1;
            freq_ref_r <= avg;
          end
          else
            freq_ref_r <= held_r;
        end
        ST_OUT:
          if (freq_ref_ready)
          begin
            freq_ref_valid_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule : analog_speed_reference_conditioner

// >>> bench/ref_cond_monitor.sv
// concurrent checks on the ports of the speed reference conditioner
// assumes ref_cond_map.svh is on the include path; bound at the foot of this file
`timescale 1ns/1ps
`include "ref_cond_map.svh"
module ref_cond_monitor
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`FREQ_W-1:0] freq_ref,
  input wire logic freq_ref_valid,
  input wire logic freq_ref_ready,
  input wire logic [4:0] filter_sample_display
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_write_answer;
    ##2 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_write_taken |-> s_write_answer)
    else $error("write response late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFS_STATUS
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_unmapped_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > `OFS_STATUS
    |-> ##[1:20] (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR))
    else $error("unmapped write not refused");
  a_result_hold: assert property (
    freq_ref_valid && !freq_ref_ready |=> freq_ref_valid && $stable(freq_ref))
    else $error("result changed while stalled");
  a_freq_limit: assert property (freq_ref_valid |-> freq_ref <= `FREQ_MAX)
    else $error("frequency above limit");
  a_filter_range: assert property (
    filter_sample_display >= 5'h01 && filter_sample_display <= `FILT_DB)
    else $error("filter setting out of range");
endmodule : ref_cond_monitor

bind analog_speed_reference_conditioner ref_cond_monitor mon (.*);

// >>> bench/analog_source_model.sv
// behavioural model of the voltage, current and potentiometer converters
// assumes send is called right after a rising edge of clk
`timescale 1ns/1ps
module analog_source_model
(
  input wire logic clk,
  input wire logic sample_ready,
  output logic sample_valid,
  output logic [9:0] volt_ref_channel,
  output logic [9:0] current_ref_channel,
  output logic [9:0] pot_ref_channel
);
  initial
  begin
    sample_valid = 1'b0;
    volt_ref_channel = 10'h155;
    current_ref_channel = 10'h2aa;
    pot_ref_channel = 10'h155;
  end

  // codes span 0 to 3ff: 0-10 V and 4-20 mA both use the full converter range
  task automatic send(input logic [9:0] v, input logic [9:0] c, input logic [9:0] p,
    input int gap, input int lim, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    volt_ref_channel <= v;
    current_ref_channel <= c;
    pot_ref_channel <= p;
    sample_valid <= 1'b1;
    for (n = 0; n < lim && !ok; n++)
    begin
      @(posedge clk);
      ok = sample_ready;
    end
    // a released line shows the inverse so a stale value is never mistaken for data
    sample_valid <= 1'b0;
    volt_ref_channel <= ~v;
    current_ref_channel <= ~c;
    pot_ref_channel <= ~p;
  endtask : send
endmodule : analog_source_model

// >>> bench/analog_speed_reference_conditioner_tb.sv
// self-checking bench for the speed reference conditioner
// assumes the source model drives samples; registers go over AXI4-Lite
`timescale 1ns/1ps
`include "ref_cond_map.svh"
module analog_speed_reference_conditioner_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic freq_ref_ready = 1'b0, channel_select_input = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sample_valid, sample_ready, freq_ref_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] freq_ref;
  logic [4:0] filter_sample_display;
  logic [9:0] volt_ref_channel, current_ref_channel, pot_ref_channel;
  int mismatches = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  analog_speed_reference_conditioner DUT (.*);
  analog_source_model src (.*);

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic hang;
    mismatches++;
    $display("ERROR %0t: wait ran out", $time);
    end_of_test();
  endtask : hang

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // expected frequency of one channel, 0.1 Hz units
  function automatic int fmap(input int c, input int sf, input int ef, input int ws,
    input int we, input int bz);
    int ps;
    int fs;
    // signed copies, so a falling line does not turn the sum unsigned
    ps = int'(`PCT_SCALE);
    fs = int'(`ADC_FS);
    if (c * ps < ws * fs) return bz ? 0 : sf;
    if (c * ps >= we * fs) return ef;
    return sf + (ef - sf) * (c * ps - ws * fs) / ((we - ws) * fs);
  endfunction : fmap

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; !done; n++)
    begin
      @(posedge clk);
      if (n > 200) hang();
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    done = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; !done; n++)
    begin
      @(posedge clk);
      if (n > 200) hang();
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axr

  task automatic cfg(input logic [31:0] ctl, vf, vw, cf, cw);
    logic [1:0] r;
    axw(`OFS_CTRL, ctl, r);
    axw(`OFS_VOLT_FREQ, vf, r);
    axw(`OFS_VOLT_WIN, vw, r);
    axw(`OFS_CURR_FREQ, cf, r);
    axw(`OFS_CURR_WIN, cw, r);
    check(r, `RESP_OKAY);
  endtask : cfg

  task automatic take(output logic [11:0] f, input bit rel);
    int n;
    if (!freq_ref_ready) freq_ref_ready <= 1'b1;
    for (n = 0; n >= 0; n++)
    begin
      @(posedge clk);
      if (n > 300) hang();
      if (freq_ref_valid) break;
    end
    f = freq_ref;
    if (rel) freq_ref_ready <= 1'b0;
  endtask : take

  task automatic feed(input logic [9:0] v, input int k);
    logic [11:0] f;
    bit ok;
    repeat (k)
    begin
      src.send(v, 10'h000, 10'h000, 0, 100, ok);
      take(f, 1'b1);
    end
  endtask : feed

  task automatic run(input logic [9:0] v, c, p, input logic s, input int gap, input int e);
    logic [11:0] f;
    bit ok;
    channel_select_input <= s;
    src.send(v, c, p, gap, 100, ok);
    take(f, 1'b1);
    check(f, e);
  endtask : run

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    axr(`OFS_CTRL, d, r);
    check(d, 32'h0000002c);
    axr(`OFS_VOLT_WIN, d, r);
    check(d, 32'h00640000);
    axr(`OFS_CURR_WIN, d, r);
    check(d, 32'h00640000);
    axr(8'h18, d, r);
    check({d, r}, {32'h0, `RESP_SLVERR});
    axw(8'h18, 32'hffffffff, r);
    check(r, `RESP_SLVERR);
    check(filter_sample_display, `FILT_DEF_EU);
    $display("test reset done");
  endtask : t_reset

  task automatic t_select;
    logic [1:0] r;
    int v, c, e;
    v = fmap(10, 'h064, 'hc61, 0, 'h64, 1);
    c = fmap(20, 0, 'h3ff, 0, 'h64, 1);
    cfg(32'h1c, 32'h0c610064, 32'h00640000, 32'h03ff0000, 32'h00640000);
    for (int sel = 0; sel < 4; sel++)
    begin
      axw(`OFS_CTRL, 32'h1c | sel, r);
      for (int s = 0; s < 2; s++)
      begin
        case (sel)
          0: e = s ? c : v;
          1: e = (v + c > `FREQ_MAX) ? `FREQ_MAX : v + c;
          default: e = s ? `FREQ_MAX : (sel == 2 ? v : c);
        endcase
        run(10'h00a, 10'h014, 10'h3ff, s[0], s, e);
      end
    end
    $display("test select done");
  endtask : t_select

  task automatic t_window;
    logic [1:0] r;
    int cd[2] = '{'h010, 'h3ff};
    logic [9:0] x;
    cfg(32'h10, 32'h0c610064, 32'h003c0014, 32'h03ff00c8, 32'h003c0014);
    for (int bz = 0; bz < 2; bz++)
    begin
      axw(`OFS_CTRL, 32'h10 | (bz << 2) | (bz << 3), r);
      foreach (cd[i])
      begin
        x = 10'(cd[i]);
        run(x, 10'h000, 10'h000, 1'b0, 0, fmap(cd[i], 'h064, 'hc61, 'h14, 'h3c, bz));
        run(10'h000, x, 10'h000, 1'b1, 2, fmap(cd[i], 'hc8, 'h3ff, 'h14, 'h3c, bz));
      end
    end
    axw(`OFS_VOLT_FREQ, 32'h00640c61, r);
    run(10'h200, 10'h000, 10'h000, 1'b0, 0, fmap('h200, 'hc61, 'h064, 'h14, 'h3c, 1));
    axw(`OFS_VOLT_WIN, 32'h00320032, r);
    run(10'h200, 10'h000, 10'h000, 1'b0, 0, 'h064);
    run(10'h1ff, 10'h000, 10'h000, 1'b0, 0, 0);
    $display("test window done");
  endtask : t_window

  task automatic t_average;
    logic [1:0] r;
    cfg(32'h4c, 32'h03ff0000, 32'h00640000, 32'h03ff0000, 32'h00640000);
    feed(10'h064, 3);
    run(10'h064, 10'h000, 10'h000, 1'b0, 0, 'h064);
    run(10'h12c, 10'h000, 10'h000, 1'b0, 0, 'h096);
    axw(`OFS_CTRL, 32'h0c, r);
    check(filter_sample_display, 5'h01);
    axw(`OFS_CTRL, 32'h10c, r);
    feed(10'h190, 15);
    run(10'h190, 10'h000, 10'h000, 1'b0, 0, 'h190);
    axw(`OFS_CTRL, 32'h1fc, r);
    check(filter_sample_display, `FILT_DB);
    run(10'h190, 10'h000, 10'h000, 1'b0, 0, 'h190);
    run(10'h1a0, 10'h000, 10'h000, 1'b0, 0, 'h191);
    run(10'h190, 10'h000, 10'h000, 1'b0, 0, 'h191);
    run(10'h180, 10'h000, 10'h000, 1'b0, 0, 'h191);
    run(10'h180, 10'h000, 10'h000, 1'b0, 0, 'h18f);
    $display("test average done");
  endtask : t_average

  task automatic t_fifo;
    logic [1:0] r;
    logic [11:0] f;
    bit ok;
    int n;
    axw(`OFS_CTRL, 32'h1c, r);
    // result side stalls so the buffer has to fill up and refuse
    for (n = 0; n < 40; n++)
    begin
      src.send(10'(n + 1), 10'h000, 10'h000, 0, 20, ok);
      if (!ok) break;
    end
    check(n >= 16 && n <= 18, 1'b1);
    for (int i = 1; i <= n; i++)
    begin
      take(f, i == n);
      check(f, i);
    end
    $display("test fifo done");
  endtask : t_fifo

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_select();
    t_window();
    t_average();
    t_fifo();
    end_of_test();
  end
endmodule : analog_speed_reference_conditioner_tb
